// [core/scp_pkg.sv]
package scp_pkg;

   // Address codes, first field B (B0 lsb) in the high nibble, field A (A0 lsb) low
   localparam int ADDR_W = 8;
   localparam logic [7:0] CODE_WR1 = 8'h82;
   localparam logic [7:0] CODE_WR2 = 8'h92;
   localparam logic [7:0] CODE_RD = 8'hA2;

   // Control word length for both write modes
   localparam int CTRL_W = 24;

   // Field layout inside the mode-two control word
   localparam int BO_LSB = 0;
   localparam int BO_N = 5;
   localparam int TBC_BIT = 5;
   localparam int DIR_LSB = 6;
   localparam int IODAT_LSB = 8;
   localparam int IO_N = 2;
   localparam int DOC_LSB = 10;
   localparam int DOC_W = 3;
   localparam int GATE_LSB = 13;
   localparam int GATE_W = 2;
   localparam logic [CTRL_W-1:0] CTRL_RST = 24'h00_0000;

   // Read-back selections
   localparam logic [2:0] RB_STATUS = 3'h0;
   localparam logic [2:0] RB_TBASE = 3'h1;
   localparam logic [2:0] RB_IO1 = 3'h2;
   localparam logic [2:0] RB_IO2 = 3'h3;

   // Timing
   localparam int CLK_KHZ = 25000;
   localparam int TB_HZ = 8;
   localparam int GATE_MS_0 = 4;
   localparam int GATE_MS_1 = 8;
   localparam int GATE_MS_2 = 32;
   localparam int GATE_MS_3 = 64;

   // Synchroniser lanes in the device
   localparam int SY_CE = 0;
   localparam int SY_CL = 1;
   localparam int SY_DI = 2;
   localparam int SY_IF = 3;
   localparam int SY_IO1 = 4;
   localparam int SY_IO2 = 5;
   localparam int SY_N = 6;

   typedef enum {SCP_MODE_NONE, SCP_MODE_WR1, SCP_MODE_WR2, SCP_MODE_RD} scp_mode_t;
   typedef enum {SCP_C_IDLE, SCP_C_ADDR, SCP_C_GAP, SCP_C_DATA, SCP_C_END} scp_cstate_t;

   // Swaps nibbles: shift order B0..B3,A0..A3 (lsb first) versus the code
   function automatic logic [7:0] addr_swap(input logic [7:0] v);
      addr_swap = {v[3:0], v[7:4]};
   endfunction: addr_swap

endpackage: scp_pkg

// [core/scp_if.sv]
`timescale 1ns/1ps
interface scp_if;
   logic chip_enable;
   logic bit_timing_input;
   logic serial_data_in;
   logic serial_data_out;

   modport dev (
      input chip_enable,
      input bit_timing_input,
      input serial_data_in,
      output serial_data_out
   );

   modport ctl (
      output chip_enable,
      output bit_timing_input,
      output serial_data_in,
      input serial_data_out
   );
endinterface: scp_if

// [core/scp_dev.sv]
`timescale 1ns/1ps
module scp_dev #(
   parameter int IF_CNT_W = 20,
   parameter int TB_HALF_CYC = scp_pkg::CLK_KHZ * 1000 / (2 * scp_pkg::TB_HZ),
   parameter int GATE_CYC_0 = scp_pkg::GATE_MS_0 * scp_pkg::CLK_KHZ,
   parameter int GATE_CYC_1 = scp_pkg::GATE_MS_1 * scp_pkg::CLK_KHZ,
   parameter int GATE_CYC_2 = scp_pkg::GATE_MS_2 * scp_pkg::CLK_KHZ,
   parameter int GATE_CYC_3 = scp_pkg::GATE_MS_3 * scp_pkg::CLK_KHZ
) (
   input wire logic sys_clk,
   input wire logic srst,
   scp_if.dev bus,
   input wire logic intermediate_freq_input,
   input wire logic lo_div_edge,
   input wire logic ref_div_edge,
   input wire logic bidir_pin_one_i,
   input wire logic bidir_pin_two_i,
   output logic bidir_pin_one_o,
   output logic bidir_pin_one_oe,
   output logic bidir_pin_two_o,
   output logic bidir_pin_two_oe,
   output logic [scp_pkg::BO_N-1:0] open_drain_out_o,
   output logic [scp_pkg::BO_N-1:0] open_drain_out_oe,
   output logic [1:0] phase_pump_out_o,
   output logic [1:0] phase_pump_out_oe,
   output logic [scp_pkg::CTRL_W-1:0] control_write_mode_one,
   output logic [scp_pkg::CTRL_W-1:0] control_write_mode_two
);

   localparam int RB_W = scp_pkg::IO_N + IF_CNT_W;
   localparam int GCNT_W = $clog2(GATE_CYC_3 + 1);
   localparam int TCNT_W = $clog2(TB_HALF_CYC + 1);
   localparam logic [4:0] CNT_FULL = 5'(scp_pkg::CTRL_W);
   localparam logic [4:0] CNT_OVER = 5'(scp_pkg::CTRL_W + 1);

   if (IF_CNT_W < 1 || TB_HALF_CYC < 1 || GATE_CYC_0 < 2 || GATE_CYC_0 > GATE_CYC_1
       || GATE_CYC_1 > GATE_CYC_2 || GATE_CYC_2 > GATE_CYC_3) begin : g_chk
      $error("scp_dev: bad parameter values");
   end

   // Pin synchronisers: three stages, a level counts once stages two and three agree
   logic [scp_pkg::SY_N-1:0] sy_in;
   logic [scp_pkg::SY_N-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_d_r;
   logic [scp_pkg::SY_N-1:0] rise, fall;

   always_comb begin
      sy_in = '0;
      sy_in[scp_pkg::SY_CE] = bus.chip_enable;
      sy_in[scp_pkg::SY_CL] = bus.bit_timing_input;
      sy_in[scp_pkg::SY_DI] = bus.serial_data_in;
      sy_in[scp_pkg::SY_IF] = intermediate_freq_input;
      sy_in[scp_pkg::SY_IO1] = bidir_pin_one_i;
      sy_in[scp_pkg::SY_IO2] = bidir_pin_two_i;
   end

   for (genvar g = 0; g < scp_pkg::SY_N; g++) begin : g_sync
      always_ff @(posedge sys_clk) begin
         if (srst) begin
            s1_r[g] <= 1'b0;
            s2_r[g] <= 1'b0;
            s3_r[g] <= 1'b0;
            lvl_r[g] <= 1'b0;
            lvl_d_r[g] <= 1'b0;
         end else begin
            s1_r[g] <= sy_in[g];
            s2_r[g] <= s1_r[g];
            s3_r[g] <= s2_r[g];
            if (s2_r[g] == s3_r[g]) begin
               lvl_r[g] <= s3_r[g];
            end
            lvl_d_r[g] <= lvl_r[g];
         end
      end
      assign rise[g] = lvl_r[g] & ~lvl_d_r[g];
      assign fall[g] = ~lvl_r[g] & lvl_d_r[g];
   end

   wire ce_lvl = lvl_r[scp_pkg::SY_CE];
   wire ce_rise = rise[scp_pkg::SY_CE];
   wire ce_fall = fall[scp_pkg::SY_CE];
   wire cl_rise = rise[scp_pkg::SY_CL];
   wire cl_fall = fall[scp_pkg::SY_CL];
   wire di_lvl = lvl_r[scp_pkg::SY_DI];

   // Serial transfer engine
   scp_pkg::scp_mode_t mode_r;
   logic [scp_pkg::ADDR_W-1:0] addr_sr_r;
   logic [scp_pkg::CTRL_W-1:0] data_sr_r;
   logic [4:0] bit_cnt_r;
   logic [RB_W-1:0] rd_sr_r;
   logic dout_r;
   logic [RB_W-1:0] rb_word;
   logic [scp_pkg::CTRL_W-1:0] word2_r;
   logic [IF_CNT_W-1:0] if_result_r;
   logic tb_r;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mode_r <= scp_pkg::SCP_MODE_NONE;
         addr_sr_r <= '0;
         data_sr_r <= '0;
         bit_cnt_r <= '0;
         rd_sr_r <= '0;
         dout_r <= 1'b0;
      end else if (ce_rise) begin
         bit_cnt_r <= '0;
         case (scp_pkg::addr_swap(addr_sr_r))
            scp_pkg::CODE_WR1: mode_r <= scp_pkg::SCP_MODE_WR1;
            scp_pkg::CODE_WR2: mode_r <= scp_pkg::SCP_MODE_WR2;
            scp_pkg::CODE_RD: begin
               mode_r <= scp_pkg::SCP_MODE_RD;
               dout_r <= rb_word[RB_W-1];
               rd_sr_r <= {rb_word[RB_W-2:0], 1'b0};
            end
            default: mode_r <= scp_pkg::SCP_MODE_NONE;
         endcase
      end else if (ce_fall) begin
         mode_r <= scp_pkg::SCP_MODE_NONE;
         dout_r <= 1'b0;
      end else if (!ce_lvl && cl_rise) begin
         addr_sr_r <= {di_lvl, addr_sr_r[scp_pkg::ADDR_W-1:1]};
      end else if (ce_lvl && cl_rise && (mode_r == scp_pkg::SCP_MODE_WR1
                                         || mode_r == scp_pkg::SCP_MODE_WR2)) begin
         data_sr_r <= {di_lvl, data_sr_r[scp_pkg::CTRL_W-1:1]};
         if (bit_cnt_r != CNT_OVER) begin
            bit_cnt_r <= bit_cnt_r + 5'd1;
         end
      end else if (ce_lvl && cl_fall && mode_r == scp_pkg::SCP_MODE_RD) begin
         dout_r <= rd_sr_r[RB_W-1];
         rd_sr_r <= {rd_sr_r[RB_W-2:0], 1'b0};
      end
   end

   assign bus.serial_data_out = dout_r;

   // Control words: only a complete 24-bit shift is applied, at enable fall
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         control_write_mode_one <= scp_pkg::CTRL_RST;
         word2_r <= scp_pkg::CTRL_RST;
      end else if (ce_fall && bit_cnt_r == CNT_FULL) begin
         if (mode_r == scp_pkg::SCP_MODE_WR1) begin
            control_write_mode_one <= data_sr_r;
         end
         if (mode_r == scp_pkg::SCP_MODE_WR2) begin
            word2_r <= data_sr_r;
         end
      end
   end

   assign control_write_mode_two = word2_r;

   // Read-back content
   wire [scp_pkg::DOC_W-1:0] rb_sel = word2_r[scp_pkg::DOC_LSB +: scp_pkg::DOC_W];
   wire io1_lvl = lvl_r[scp_pkg::SY_IO1];
   wire io2_lvl = lvl_r[scp_pkg::SY_IO2];

   always_comb begin
      rb_word = '0;
      case (rb_sel)
         scp_pkg::RB_STATUS: rb_word = {io1_lvl, io2_lvl, if_result_r};
         scp_pkg::RB_TBASE: rb_word[RB_W-1] = tb_r;
         scp_pkg::RB_IO1: rb_word[RB_W-1] = io1_lvl;
         scp_pkg::RB_IO2: rb_word[RB_W-1] = io2_lvl;
         default: rb_word = '0;
      endcase
   end

   // IF counter over a selectable gate
   logic [GCNT_W-1:0] gate_cnt_r;
   logic [GCNT_W-1:0] gate_len;
   logic [IF_CNT_W-1:0] if_cnt_r;
   wire if_edge = rise[scp_pkg::SY_IF];

   always_comb begin
      case (word2_r[scp_pkg::GATE_LSB +: scp_pkg::GATE_W])
         2'd0: gate_len = GCNT_W'(GATE_CYC_0);
         2'd1: gate_len = GCNT_W'(GATE_CYC_1);
         2'd2: gate_len = GCNT_W'(GATE_CYC_2);
         default: gate_len = GCNT_W'(GATE_CYC_3);
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         gate_cnt_r <= '0;
         if_cnt_r <= '0;
         if_result_r <= '0;
      end else if (gate_cnt_r >= gate_len - GCNT_W'(1)) begin
         gate_cnt_r <= '0;
         if_cnt_r <= '0;
         if_result_r <= (if_edge && if_cnt_r != '1) ? if_cnt_r + IF_CNT_W'(1) : if_cnt_r;
      end else begin
         gate_cnt_r <= gate_cnt_r + GCNT_W'(1);
         if (if_edge && if_cnt_r != '1) begin
            if_cnt_r <= if_cnt_r + IF_CNT_W'(1);
         end
      end
   end

   // 8 Hz time base
   logic [TCNT_W-1:0] tb_cnt_r;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tb_cnt_r <= '0;
         tb_r <= 1'b0;
      end else if (tb_cnt_r == TCNT_W'(TB_HALF_CYC - 1)) begin
         tb_cnt_r <= '0;
         tb_r <= ~tb_r;
      end else begin
         tb_cnt_r <= tb_cnt_r + TCNT_W'(1);
      end
   end

   // Port pins, all open drain
   wire [scp_pkg::IO_N-1:0] io_dir = word2_r[scp_pkg::DIR_LSB +: scp_pkg::IO_N];
   wire [scp_pkg::IO_N-1:0] io_dat = word2_r[scp_pkg::IODAT_LSB +: scp_pkg::IO_N];

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         open_drain_out_o <= '0;
         open_drain_out_oe <= '0;
         bidir_pin_one_o <= 1'b0;
         bidir_pin_one_oe <= 1'b0;
         bidir_pin_two_o <= 1'b0;
         bidir_pin_two_oe <= 1'b0;
      end else begin
         open_drain_out_o <= '0;
         open_drain_out_oe <= word2_r[scp_pkg::BO_LSB +: scp_pkg::BO_N];
         if (word2_r[scp_pkg::TBC_BIT]) begin
            open_drain_out_oe[0] <= tb_r;
         end
         bidir_pin_one_o <= 1'b0;
         bidir_pin_one_oe <= io_dir[0] & io_dat[0];
         bidir_pin_two_o <= 1'b0;
         bidir_pin_two_oe <= io_dir[1] & io_dat[1];
      end
   end

   // Phase detector and charge pumps
   logic up_r, dn_r;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         up_r <= 1'b0;
         dn_r <= 1'b0;
      end else if ((up_r | lo_div_edge) && (dn_r | ref_div_edge)) begin
         up_r <= 1'b0;
         dn_r <= 1'b0;
      end else begin
         up_r <= up_r | lo_div_edge;
         dn_r <= dn_r | ref_div_edge;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         phase_pump_out_o <= '0;
         phase_pump_out_oe <= '0;
      end else begin
         phase_pump_out_o <= {2{up_r}};
         phase_pump_out_oe <= {2{up_r ^ dn_r}};
      end
   end

endmodule: scp_dev

// [core/scp_ctl.sv]
`timescale 1ns/1ps
module scp_ctl #(
   parameter int HALF_CYC = 8,
   parameter int RD_MAX = 32
) (
   input wire logic sys_clk,
   input wire logic srst,
   scp_if.ctl bus,
   input wire logic req,
   input wire logic [7:0] req_code,
   input wire logic [scp_pkg::CTRL_W-1:0] req_wdata,
   input wire logic [$clog2(RD_MAX+1)-1:0] req_rd_len,
   output logic busy,
   output logic done,
   output logic [RD_MAX-1:0] rdata
);

   localparam int HC_W = $clog2(HALF_CYC);
   localparam int LEN_W = $clog2(RD_MAX + 1);
   localparam int SH_W = (RD_MAX > scp_pkg::CTRL_W) ? RD_MAX : scp_pkg::CTRL_W;

   if (HALF_CYC < 8 || RD_MAX < 1) begin : g_chk
      $error("scp_ctl: bad parameter values");
   end

   scp_pkg::scp_cstate_t st_r;
   logic [HC_W-1:0] hc_r;
   logic [SH_W-1:0] sh_r;
   logic [LEN_W-1:0] cnt_r, len_r;
   logic rd_r;
   logic ce_r, cl_r, di_r;

   wire tick = (hc_r == HC_W'(HALF_CYC - 1));

   always_ff @(posedge sys_clk) begin
      if (srst || st_r == scp_pkg::SCP_C_IDLE || tick) begin
         hc_r <= '0;
      end else begin
         hc_r <= hc_r + HC_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_r <= scp_pkg::SCP_C_IDLE;
         sh_r <= '0;
         cnt_r <= '0;
         len_r <= '0;
         rd_r <= 1'b0;
         ce_r <= 1'b0;
         cl_r <= 1'b0;
         di_r <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         rdata <= '0;
      end else begin
         done <= 1'b0;
         case (st_r)
            scp_pkg::SCP_C_IDLE: begin
               if (req) begin
                  sh_r <= SH_W'(scp_pkg::addr_swap(req_code));
                  di_r <= req_code[4];
                  rd_r <= (req_code == scp_pkg::CODE_RD);
                  len_r <= (req_code == scp_pkg::CODE_RD) ? req_rd_len
                                                          : LEN_W'(scp_pkg::CTRL_W);
                  cnt_r <= '0;
                  busy <= 1'b1;
                  st_r <= scp_pkg::SCP_C_ADDR;
               end
            end
            scp_pkg::SCP_C_ADDR, scp_pkg::SCP_C_DATA: begin
               if (tick && !cl_r) begin
                  cl_r <= 1'b1;
               end else if (tick) begin
                  cl_r <= 1'b0;
                  if (st_r == scp_pkg::SCP_C_DATA && rd_r) begin
                     rdata <= {rdata[RD_MAX-2:0], bus.serial_data_out};
                  end
                  sh_r <= {1'b0, sh_r[SH_W-1:1]};
                  di_r <= sh_r[1];
                  cnt_r <= cnt_r + LEN_W'(1);
                  if (st_r == scp_pkg::SCP_C_ADDR && cnt_r == LEN_W'(scp_pkg::ADDR_W - 1)) begin
                     st_r <= scp_pkg::SCP_C_GAP;
                  end else if (st_r == scp_pkg::SCP_C_DATA && cnt_r == len_r - LEN_W'(1)) begin
                     st_r <= scp_pkg::SCP_C_END;
                  end
               end
            end
            scp_pkg::SCP_C_GAP: begin
               if (tick && !ce_r) begin
                  ce_r <= 1'b1;
                  sh_r <= SH_W'(req_wdata);
                  di_r <= rd_r ? 1'b0 : req_wdata[0];
               end else if (tick) begin
                  cnt_r <= '0;
                  st_r <= (len_r == '0) ? scp_pkg::SCP_C_END : scp_pkg::SCP_C_DATA;
               end
            end
            scp_pkg::SCP_C_END: begin
               if (tick && ce_r) begin
                  ce_r <= 1'b0;
                  di_r <= 1'b0;
               end else if (tick) begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  st_r <= scp_pkg::SCP_C_IDLE;
               end
            end
            default: st_r <= scp_pkg::SCP_C_IDLE;
         endcase
      end
   end

   assign bus.chip_enable = ce_r;
   assign bus.bit_timing_input = cl_r;
   assign bus.serial_data_in = di_r;

endmodule: scp_ctl

// [sim/scp_properties.sv]
`timescale 1ns/1ps
module scp_properties (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic chip_enable,
   input wire logic bit_timing_input,
   input wire logic serial_data_in,
   input wire logic serial_data_out
);
   logic cl_q;
   logic ce_q;
   logic [5:0] n_rise;
   logic [7:0] addr_sh;
   logic [7:0] code;
   logic is_wr;
   assign code = {addr_sh[3:0], addr_sh[7:4]};
   assign is_wr = code == scp_pkg::CODE_WR1 || code == scp_pkg::CODE_WR2;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   always_ff @(posedge sys_clk) begin
      cl_q <= bit_timing_input;
      ce_q <= chip_enable;
   end
   // Clock rises since enable fell, address bits caught first bit lowest
   always_ff @(posedge sys_clk) begin
      if (srst || (ce_q && !chip_enable)) begin
         n_rise <= 6'h0;
         addr_sh <= 8'h00;
      end else if (bit_timing_input && !cl_q) begin
         n_rise <= n_rise + 6'h1;
         if (!chip_enable) begin
            addr_sh <= {serial_data_in, addr_sh[7:1]};
         end
      end
   end
   a_reset_idle: assert property (disable iff (1'b0)
      srst |=> !chip_enable && !bit_timing_input && !serial_data_out)
      else $error("link not idle after reset");
   a_addr_bits: assert property ($rose(chip_enable) |-> n_rise == 6'h8)
      else $error("address not eight bits");
   a_write_len: assert property ($fell(chip_enable) && is_wr |-> n_rise == 6'h20)
      else $error("write not 24 data bits");
   a_ce_quiet_clock: assert property ($changed(chip_enable)
      |-> !bit_timing_input && !$past(bit_timing_input))
      else $error("enable moved with clock high");
   a_di_stable: assert property (bit_timing_input && $past(bit_timing_input)
      |-> $stable(serial_data_in))
      else $error("data in moved while clock high");
   a_clk_width: assert property ($rose(bit_timing_input) |-> bit_timing_input[*4])
      else $error("shift clock pulse too short");
   a_do_stable: assert property (chip_enable && bit_timing_input
      |-> $stable(serial_data_out))
      else $error("data out moved while clock high");
   a_do_clear: assert property ($fell(chip_enable) |-> ##[1:8] !serial_data_out)
      else $error("data out not cleared after transfer");
   a_ce_held: assert property ($rose(chip_enable) |-> chip_enable[*4])
      else $error("enable dropped early");
endmodule: scp_properties

// [sim/scp_test.sv]
`timescale 1ns/1ps
module scp_test;
   logic sys_clk;
   logic srst;
   logic req;
   logic [7:0] req_code;
   logic [23:0] req_wdata;
   logic [5:0] req_rd_len;
   logic busy, done, prev;
   logic [31:0] rdata;
   logic if_in, lo_edge, ref_edge, ext1, ext2, pin1, pin2;
   logic p1_o, p1_oe, p2_o, p2_oe;
   logic [4:0] od_o, od_oe;
   logic [1:0] pp_o, pp_oe;
   logic [23:0] word1, word2;
   int fail_count, n_tests, cyc, n, i, k;
   scp_if bus ();
   scp_ctl i_scp_ctl (.sys_clk(sys_clk), .srst(srst), .bus(bus.ctl), .req(req),
      .req_code(req_code), .req_wdata(req_wdata), .req_rd_len(req_rd_len), .busy(busy),
      .done(done), .rdata(rdata));
   scp_dev #(.TB_HALF_CYC(10), .GATE_CYC_0(20), .GATE_CYC_1(40), .GATE_CYC_2(80),
      .GATE_CYC_3(160)) i_scp_dev (.sys_clk(sys_clk), .srst(srst), .bus(bus.dev),
      .intermediate_freq_input(if_in), .lo_div_edge(lo_edge), .ref_div_edge(ref_edge),
      .bidir_pin_one_i(pin1), .bidir_pin_two_i(pin2), .bidir_pin_one_o(p1_o),
      .bidir_pin_one_oe(p1_oe), .bidir_pin_two_o(p2_o), .bidir_pin_two_oe(p2_oe),
      .open_drain_out_o(od_o), .open_drain_out_oe(od_oe), .phase_pump_out_o(pp_o),
      .phase_pump_out_oe(pp_oe), .control_write_mode_one(word1),
      .control_write_mode_two(word2));
   scp_properties i_scp_properties (.sys_clk(sys_clk), .srst(srst),
      .chip_enable(bus.chip_enable), .bit_timing_input(bus.bit_timing_input),
      .serial_data_in(bus.serial_data_in), .serial_data_out(bus.serial_data_out));
   // Open-drain wire: low when the device pulls, else the far end's level
   assign pin1 = p1_oe ? 1'b0 : ext1;
   assign pin2 = p2_oe ? 1'b0 : ext2;
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // IF input period of four cycles; hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc[0]) begin
         if_in <= ~if_in;
      end
      if (cyc == 60000) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask: chk
   task automatic go(input logic [7:0] code, input logic [23:0] w, input logic [5:0] len);
      @(posedge sys_clk);
      req <= 1'b1;
      req_code <= code;
      req_wdata <= w;
      req_rd_len <= len;
      @(posedge sys_clk);
      req <= 1'b0;
   endtask: go
   task automatic fin;
      k = 0;
      while (done !== 1'b1 && k < 3000) begin
         @(negedge sys_clk);
         k++;
      end
      chk({30'h0, busy, done}, 32'h1);
      repeat (4) @(negedge sys_clk);
   endtask: fin
   task automatic xfer(input logic [7:0] code, input logic [23:0] w, input logic [5:0] len);
      go(code, w, len);
      fin();
   endtask: xfer
   task automatic pump(input logic lo, input logic rf, input logic [3:0] exp);
      @(posedge sys_clk);
      lo_edge <= lo;
      ref_edge <= rf;
      @(posedge sys_clk);
      lo_edge <= 1'b0;
      ref_edge <= 1'b0;
      repeat (3) @(negedge sys_clk);
      chk({28'h0, pp_oe, pp_o & pp_oe}, {28'h0, exp});
   endtask: pump
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask: end_sim
   initial begin
      srst = 1'b1;
      req = 1'b0;
      req_code = 8'h00;
      req_wdata = 24'h00_0000;
      req_rd_len = 6'h00;
      if_in = 1'b0;
      lo_edge = 1'b0;
      ref_edge = 1'b0;
      ext1 = 1'b1;
      ext2 = 1'b0;
      cyc = 0;
      fail_count = 0;
      n_tests = 0;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (6) @(negedge sys_clk);
      chk({20'h0, od_o, od_oe, p1_oe, p2_oe}, 32'h0);
      xfer(scp_pkg::CODE_WR1, 24'hA5_1234, 6'h00);
      chk({8'h00, word1}, 32'h00A5_1234);
      chk({8'h00, word2}, 32'h0000_0000);
      for (i = 0; i < 5; i++) begin
         xfer(scp_pkg::CODE_WR2, 24'h00_0001 << i, 6'h00);
         chk({22'h0, od_o, od_oe}, 32'h1 << i);
      end
      go(scp_pkg::CODE_WR2, 24'h00_0003, 6'h00);
      repeat (300) @(negedge sys_clk);
      chk({26'h0, busy, od_oe}, 32'h30);
      fin();
      chk({27'h0, od_oe}, 32'h3);
      for (i = 0; i < 3; i++) begin
         xfer(8'h28 + 8'(i), 24'h00_0010, 6'h00);
         chk({3'h0, od_oe, word1}, {8'h03, 24'hA5_1234});
      end
      xfer(scp_pkg::CODE_WR2, 24'h00_0140, 6'h00);
      chk({28'h0, p1_o, p2_o, p1_oe, p2_oe}, 32'h2);
      xfer(scp_pkg::CODE_WR2, 24'h00_0280, 6'h00);
      chk({28'h0, p1_o, p2_o, p1_oe, p2_oe}, 32'h1);
      xfer(scp_pkg::CODE_WR2, 24'h00_0040, 6'h00);
      chk({30'h0, p1_oe, p2_oe}, 32'h0);
      xfer(scp_pkg::CODE_WR2, 24'h00_0300, 6'h00);
      chk({30'h0, p1_oe, p2_oe}, 32'h0);
      for (i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         ext1 <= i[0];
         ext2 <= i[0];
         xfer(scp_pkg::CODE_WR2, {11'h0, i[1] ? scp_pkg::RB_IO2 : scp_pkg::RB_IO1, 10'h0}, 6'h00);
         xfer(scp_pkg::CODE_RD, 24'h00_0000, 6'h04);
         chk({28'h0, rdata[3:0]}, {28'h0, i[0], 3'h0});
      end
      xfer(scp_pkg::CODE_WR2, 24'h00_0020, 6'h00);
      prev = od_oe[0];
      n = 0;
      repeat (200) begin
         @(negedge sys_clk);
         if (od_oe[0] !== prev) begin
            n++;
         end
         prev = od_oe[0];
      end
      chk({31'h0, n >= 19 && n <= 21}, 32'h1);
      @(posedge sys_clk);
      ext1 <= 1'b1;
      ext2 <= 1'b0;
      for (i = 0; i < 4; i++) begin
         xfer(scp_pkg::CODE_WR2, {9'h0, i[1:0], 13'h0}, 6'h00);
         repeat (400) @(negedge sys_clk);
         xfer(scp_pkg::CODE_RD, 24'h00_0000, 6'h16);
         n = 5 << i;
         chk({31'h0, rdata[19:0] >= n - 1 && rdata[19:0] <= n + 1}, 32'h1);
         chk({30'h0, rdata[21:20]}, 32'h2);
      end
      pump(1'b1, 1'b0, 4'hF);
      pump(1'b0, 1'b1, 4'h0);
      pump(1'b0, 1'b1, 4'hC);
      pump(1'b1, 1'b0, 4'h0);
      pump(1'b1, 1'b1, 4'h0);
      end_sim();
   end
endmodule: scp_test
